//--- hrpwm_chk.sv
// Port checker for hrpwm_top, bound into every instance.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module hrpwm_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [23:0] duty_i,
  input wire logic        sync_i,
  input wire logic        pwm_a_o,
  input wire logic        pwm_b_o,
  input wire logic [3:0]  fine_a_o,
  input wire logic [3:0]  fine_b_o,
  input wire logic        sync_o,
  input wire logic        error_converter_start_o,
  input wire logic        blank_a_o,
  input wire logic        blank_b_o,
  input wire logic        period_irq_o,
  input wire logic        housekeeping_converter_start_o
);
  logic        ctl_wr;
  logic [12:0] ctrl_q;
  logic [1:0]  since_q;

  assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                  && wb_adr_i == hrpwm_pkg::ADR_CTRL;

  // Shadow of the control word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= 13'h0000;
    else
    begin
      if (ctl_wr && wb_sel_i[0])
        ctrl_q[7:0] <= wb_dat_i[7:0];
      if (ctl_wr && wb_sel_i[1])
        ctrl_q[12:8] <= wb_dat_i[12:8];
    end
  end

  // Cycles since the last control write
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ctl_wr)
      since_q <= 2'h0;
    else if (since_q != 2'h3)
      since_q <= since_q + 2'h1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data without ack");
  a_irq_pair: assert property (period_irq_o == housekeeping_converter_start_o)
    else $error("converter trigger differs from period interrupt");
  a_irq_pulse: assert property (period_irq_o |=> !period_irq_o)
    else $error("period interrupt longer than one cycle");
  a_sync_pulse: assert property (sync_o |=> !sync_o)
    else $error("sync out longer than one cycle");
  a_idle_level: assert property ((since_q == 2'h3 && !ctrl_q[0]) |->
    pwm_a_o == ctrl_q[1] && pwm_b_o == ctrl_q[1])
    else $error("disabled outputs not at inactive level");
  a_idle_quiet: assert property ((since_q == 2'h3 && !ctrl_q[0]) |-> !sync_o)
    else $error("sync out while disabled");
  a_fine_off: assert property ((since_q == 2'h3 && !(ctrl_q[2] && ctrl_q[7])) |->
    fine_a_o == 4'h0 && fine_b_o == 4'h0)
    else $error("fine code while fine mode off");
endmodule

bind hrpwm_top hrpwm_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .duty_i(duty_i), .sync_i(sync_i),
  .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .fine_a_o(fine_a_o), .fine_b_o(fine_b_o),
  .sync_o(sync_o), .error_converter_start_o(error_converter_start_o),
  .blank_a_o(blank_a_o), .blank_b_o(blank_b_o), .period_irq_o(period_irq_o),
  .housekeeping_converter_start_o(housekeeping_converter_start_o)
);
`default_nettype wire

//--- hrpwm_edge.sv
// One edge comparator: target position plus signed adjust against the counter.
// Assumes counter and settings come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module hrpwm_edge (
  input  wire logic [hrpwm_pkg::CNT_W-1:0]  cnt_i,
  input  wire logic [hrpwm_pkg::POS_W-1:0]  pos_i,
  input  wire logic [hrpwm_pkg::ADJ_W-1:0]  adj_i,
  input  wire logic [hrpwm_pkg::FINE_W-1:0] fine_mask_i,
  output logic                              hit_o,
  output logic [hrpwm_pkg::FINE_W-1:0]      fine_o
);
  logic signed [hrpwm_pkg::POS_W+1:0] tgt;
  logic [hrpwm_pkg::CNT_W-1:0]        coarse;

  always_comb
  begin
    // Signed adjust moves the edge both ways
    tgt = $signed({2'b00, pos_i}) + $signed(adj_i);
    coarse = tgt[hrpwm_pkg::POS_W-1:hrpwm_pkg::FINE_W];
    fine_o = tgt[hrpwm_pkg::FINE_W-1:0] & fine_mask_i;
    if (tgt < 0)
    begin
      coarse = '0;
      fine_o = '0;
    end
    else if (tgt[hrpwm_pkg::POS_W+1:hrpwm_pkg::POS_W] != 2'b00)
    begin
      coarse = '1;
    end
    hit_o = (cnt_i == coarse);
  end
endmodule
`default_nettype wire

//--- hrpwm_pkg.sv
// Constants and types for the fine-resolution dual-output PWM channel.
// Assumes a single 25 MHz system clock; used by hrpwm_top and hrpwm_edge.
package hrpwm_pkg;
  localparam int CNT_W  = 14;
  localparam int FINE_W = 4;
  localparam int POS_W  = CNT_W + FINE_W;
  localparam int ADJ_W  = 16;
  localparam int QCNT_W = CNT_W - 2;
  localparam int DUTY_W = 24;
  localparam int DUTY_FRAC = 23;
  localparam int CLK_HZ = 25000000;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_PERIOD  = 8'h04;
  localparam logic [7:0] ADR_A_RISE  = 8'h08;
  localparam logic [7:0] ADR_A_FALL  = 8'h0C;
  localparam logic [7:0] ADR_B_RISE  = 8'h10;
  localparam logic [7:0] ADR_B_FALL  = 8'h14;
  localparam logic [7:0] ADR_ADJUST  = 8'h18;
  localparam logic [7:0] ADR_SAMPLE  = 8'h1C;
  localparam logic [7:0] ADR_PHASE   = 8'h20;
  localparam logic [7:0] ADR_BLANK_A = 8'h24;
  localparam logic [7:0] ADR_BLANK_B = 8'h28;
  localparam logic [7:0] ADR_STATUS  = 8'h2C;

  localparam int HI_LSB = 16;
  localparam logic [CNT_W-1:0] PERIOD_RST = 14'h00FF;

  typedef struct packed {
    logic [18:0] rsvd;
    logic        closed_loop;
    logic [3:0]  int_div;
    logic        all_phase_clocks_enable;
    logic [1:0]  fine_step_scale;
    logic [1:0]  oversample;
    logic        fine_multi_output_enable;
    logic        polarity;
    logic        enable;
  } hrpwm_ctrl_type;

  localparam hrpwm_ctrl_type CTRL_RST = '0;
endpackage

//--- hrpwm_sib.sv
// Sibling channel model: one-cycle sync pulse every PER clocks.
// Assumes the channel's clock; silent while run_i is low.
`timescale 1ns/1ns
`default_nettype none
module hrpwm_sib #(
  parameter int PER = 15
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      sync_o
);
  int   cnt_q;
  logic hit_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q <= 0;
      hit_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
      hit_q <= (cnt_q == PER - 2);
    end
  end

  assign sync_o = run_i & hit_q;
endmodule
`default_nettype wire

//--- hrpwm_top.sv
// Dual-output PWM channel with fine edge codes, Wishbone registers.
// Assumes clk_i is the PWM counting clock; sync_i comes from outside.
`timescale 1ns/1ns
`default_nettype none
module hrpwm_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [23:0] duty_i,
  input  wire logic        sync_i,
  output logic             pwm_a_o,
  output logic             pwm_b_o,
  output logic      [3:0]  fine_a_o,
  output logic      [3:0]  fine_b_o,
  output logic             sync_o,
  output logic             error_converter_start_o,
  output logic             blank_a_o,
  output logic             blank_b_o,
  output logic             period_irq_o,
  output logic             housekeeping_converter_start_o
);
  localparam int CW = hrpwm_pkg::CNT_W;
  localparam int PW = hrpwm_pkg::POS_W;
  localparam int AW = hrpwm_pkg::ADJ_W;
  localparam int QW = hrpwm_pkg::QCNT_W;
  localparam int FW = hrpwm_pkg::FINE_W;
  localparam int HL = hrpwm_pkg::HI_LSB;
  localparam int DUTY_W_M = hrpwm_pkg::DUTY_FRAC - 1;

  hrpwm_pkg::hrpwm_ctrl_type ctrl_q;
  hrpwm_pkg::hrpwm_ctrl_type ctrl_w;
  logic [CW-1:0] period_shadow_q;
  logic [CW-1:0] period_q;
  logic [CW-1:0] a_rise_q;
  logic [PW-1:0] a_fall_q;
  logic [PW-1:0] b_rise_q;
  logic [PW-1:0] b_fall_q;
  logic [AW-1:0] adj_a_q;
  logic [AW-1:0] adj_b_q;
  logic [QW-1:0] samp1_q;
  logic [QW-1:0] samp2_q;
  logic [CW-1:0] phase_q;
  logic [CW-1:0] blk_a_beg_q;
  logic [CW-1:0] blk_a_end_q;
  logic [CW-1:0] blk_b_beg_q;
  logic [CW-1:0] blk_b_end_q;
  logic [CW-1:0] cnt_q;
  logic [1:0]    qdiv_q;
  logic          sync1_q;
  logic          sync2_q;
  logic          sync3_q;
  logic [QW-1:0] next_samp_q;
  logic [3:0]    samp_k_q;
  logic [7:0]    pcnt_q;
  logic          a_q;
  logic          b_q;

  logic          wb_req;
  logic          wr;
  logic [31:0]   rd_d;
  logic          sync_rise;
  logic          wrap;
  logic          run;
  logic          q_en;
  logic          hr_on;
  logic [FW-1:0] fmask;
  logic [PW-1:0] ontime;
  logic [7:0]    div_cnt;
  logic          samp1_hit;
  logic          samp2_hit;
  logic [3:0]    os_n;
  logic [QW-1:0] os_step;
  logic          a_d;
  logic          b_d;
  logic [PW-1:0] pos [4];
  logic [AW-1:0] adj [4];
  logic [3:0]    hit;
  logic [FW-1:0] fine [4];
  logic [31:0]   wm;
  logic [47:0]   prod;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] div_lookup(input logic [3:0] s);
    case (s)
      4'h1:    div_lookup = 8'h00;
      4'h2:    div_lookup = 8'h01;
      4'h3:    div_lookup = 8'h03;
      4'h4:    div_lookup = 8'h07;
      4'h5:    div_lookup = 8'h0F;
      4'h6:    div_lookup = 8'h1F;
      4'h7:    div_lookup = 8'h2F;
      4'h8:    div_lookup = 8'h3F;
      4'h9:    div_lookup = 8'h4F;
      4'hA:    div_lookup = 8'h5F;
      4'hB:    div_lookup = 8'h7F;
      4'hC:    div_lookup = 8'h9F;
      4'hD:    div_lookup = 8'hBF;
      4'hE:    div_lookup = 8'hDF;
      default: div_lookup = 8'hFF;
    endcase
  endfunction

  // Bus access
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = wb_req & wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we_i) ? rd_d : 32'h0000_0000;
    end
  end

  always_comb
  begin
    case (wb_adr_i)
      hrpwm_pkg::ADR_CTRL:    rd_d = ctrl_q;
      hrpwm_pkg::ADR_PERIOD:  rd_d = 32'(period_shadow_q);
      hrpwm_pkg::ADR_A_RISE:  rd_d = 32'(a_rise_q);
      hrpwm_pkg::ADR_A_FALL:  rd_d = 32'(a_fall_q);
      hrpwm_pkg::ADR_B_RISE:  rd_d = 32'(b_rise_q);
      hrpwm_pkg::ADR_B_FALL:  rd_d = 32'(b_fall_q);
      hrpwm_pkg::ADR_ADJUST:  rd_d = {adj_b_q, adj_a_q};
      hrpwm_pkg::ADR_SAMPLE:  rd_d = {4'h0, samp2_q, 4'h0, samp1_q};
      hrpwm_pkg::ADR_PHASE:   rd_d = 32'(phase_q);
      hrpwm_pkg::ADR_BLANK_A: rd_d = {2'b00, blk_a_end_q, 2'b00, blk_a_beg_q};
      hrpwm_pkg::ADR_BLANK_B: rd_d = {2'b00, blk_b_end_q, 2'b00, blk_b_beg_q};
      hrpwm_pkg::ADR_STATUS:  rd_d = {8'h00, pcnt_q, b_q, a_q, cnt_q};
      default:                rd_d = 32'h0000_0000;
    endcase
  end

  // Byte-lane merge into the addressed word
  always_comb
  begin
    wm          = merge(rd_d, wb_dat_i, wb_sel_i);
    ctrl_w      = wm;
    ctrl_w.rsvd = '0;
  end

  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q          <= hrpwm_pkg::CTRL_RST;
      period_shadow_q <= hrpwm_pkg::PERIOD_RST;
      a_rise_q        <= '0;
      a_fall_q        <= '0;
      b_rise_q        <= '0;
      b_fall_q        <= '0;
      adj_a_q         <= '0;
      adj_b_q         <= '0;
      samp1_q         <= '0;
      samp2_q         <= '0;
      phase_q         <= '0;
      blk_a_beg_q     <= '0;
      blk_a_end_q     <= '0;
      blk_b_beg_q     <= '0;
      blk_b_end_q     <= '0;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        hrpwm_pkg::ADR_CTRL:   ctrl_q             <= ctrl_w;
        hrpwm_pkg::ADR_PERIOD: period_shadow_q    <= wm[CW-1:0];
        hrpwm_pkg::ADR_A_RISE: a_rise_q           <= wm[CW-1:0];
        hrpwm_pkg::ADR_A_FALL: a_fall_q           <= wm[PW-1:0];
        hrpwm_pkg::ADR_B_RISE: b_rise_q           <= wm[PW-1:0];
        hrpwm_pkg::ADR_B_FALL: b_fall_q           <= wm[PW-1:0];
        hrpwm_pkg::ADR_ADJUST: {adj_b_q, adj_a_q} <= wm;
        hrpwm_pkg::ADR_SAMPLE:
        begin
          samp1_q <= wm[QW-1:0];
          samp2_q <= wm[HL +: QW];
        end
        hrpwm_pkg::ADR_PHASE:  phase_q <= wm[CW-1:0];
        hrpwm_pkg::ADR_BLANK_A:
        begin
          blk_a_beg_q <= wm[CW-1:0];
          blk_a_end_q <= wm[HL +: CW];
        end
        hrpwm_pkg::ADR_BLANK_B:
        begin
          blk_b_beg_q <= wm[CW-1:0];
          blk_b_end_q <= wm[HL +: CW];
        end
        default: ;
      endcase
    end
  end

  // Sync input synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign sync_rise = sync2_q & ~sync3_q;

  // Time base
  assign run  = ctrl_q.enable;
  assign wrap = cnt_q >= period_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
    end
    else if (~run | sync_rise | wrap)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_q <= hrpwm_pkg::PERIOD_RST;
    end
    else if (~run | wrap)
    begin
      period_q <= period_shadow_q;
    end
  end

  // Quarter-rate enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      qdiv_q <= 2'h0;
    end
    else
    begin
      qdiv_q <= qdiv_q + 1'b1;
    end
  end
  assign q_en = (qdiv_q == hrpwm_pkg::QUARTER_LAST);

  // Sample triggers with oversampling
  assign os_n      = 4'h1 << ctrl_q.oversample;
  assign os_step   = period_q[CW-1:2] >> ctrl_q.oversample;
  assign samp1_hit = run & q_en & (samp_k_q < os_n) & (cnt_q[CW-1:2] == next_samp_q);
  assign samp2_hit = run & q_en & (cnt_q[CW-1:2] == samp2_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      next_samp_q <= '0;
      samp_k_q    <= 4'h0;
    end
    else if (~run | wrap | sync_rise)
    begin
      next_samp_q <= samp1_q;
      samp_k_q    <= 4'h0;
    end
    else if (samp1_hit)
    begin
      next_samp_q <= next_samp_q + os_step;
      samp_k_q    <= samp_k_q + 1'b1;
    end
  end

  // Period interrupt divider
  assign div_cnt = div_lookup(ctrl_q.int_div);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pcnt_q       <= 8'h00;
      period_irq_o <= 1'b0;
      housekeeping_converter_start_o <= 1'b0;
    end
    else
    begin
      period_irq_o <= 1'b0;
      housekeeping_converter_start_o <= 1'b0;
      if (~run | (ctrl_q.int_div == 4'h0))
      begin
        pcnt_q <= 8'h00;
      end
      else if (wrap)
      begin
        if (pcnt_q >= div_cnt)
        begin
          pcnt_q       <= 8'h00;
          period_irq_o <= 1'b1;
          housekeeping_converter_start_o <= 1'b1;
        end
        else
        begin
          pcnt_q <= pcnt_q + 1'b1;
        end
      end
    end
  end

  // Fine resolution setup
  assign hr_on = ctrl_q.fine_multi_output_enable & ctrl_q.all_phase_clocks_enable;

  always_comb
  begin
    case (ctrl_q.fine_step_scale)
      2'h0:    fmask = 4'hF;
      2'h1:    fmask = 4'hE;
      2'h2:    fmask = 4'hC;
      default: fmask = 4'h8;
    endcase
    if (~hr_on)
    begin
      fmask = 4'h0;
    end
  end

  // Duty to on-time in fine steps
  always_comb
  begin
    prod   = 48'(duty_i[DUTY_W_M:0]) * 48'({period_q, 4'h0});
    ontime = prod[hrpwm_pkg::DUTY_FRAC +: PW];
    if (duty_i[hrpwm_pkg::DUTY_W-1])
    begin
      ontime = '0;
    end
  end

  // Edge positions
  assign pos[0] = {a_rise_q, 4'h0};
  assign pos[1] = ctrl_q.closed_loop ? {a_rise_q, 4'h0} + ontime : a_fall_q;
  assign pos[2] = b_rise_q;
  assign pos[3] = b_fall_q;
  assign adj[0] = '0;
  assign adj[1] = adj_a_q;
  assign adj[2] = '0;
  assign adj[3] = adj_b_q;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_edge
      hrpwm_edge u_edge (
        .cnt_i       (cnt_q),
        .pos_i       (pos[i]),
        .adj_i       (adj[i]),
        .fine_mask_i ((i == 0) ? 4'h0 : fmask),
        .hit_o       (hit[i]),
        .fine_o      (fine[i])
      );
    end
  endgenerate

  // Output levels
  always_comb
  begin
    a_d = a_q;
    b_d = b_q;
    if (hit[0])
    begin
      a_d = 1'b1;
    end
    if (hit[1])
    begin
      a_d = 1'b0;
    end
    if (hit[2])
    begin
      b_d = 1'b1;
    end
    if (hit[3])
    begin
      b_d = 1'b0;
    end
    if (~run)
    begin
      a_d = 1'b0;
      b_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_q      <= 1'b0;
      b_q      <= 1'b0;
      pwm_a_o  <= 1'b0;
      pwm_b_o  <= 1'b0;
      fine_a_o <= 4'h0;
      fine_b_o <= 4'h0;
    end
    else
    begin
      a_q     <= a_d;
      b_q     <= b_d;
      pwm_a_o <= a_d ^ ctrl_q.polarity;
      pwm_b_o <= b_d ^ ctrl_q.polarity;
      if (~hr_on)
      begin
        fine_a_o <= 4'h0;
      end
      else if (run & hit[1])
      begin
        fine_a_o <= fine[1];
      end
      else if (run & hit[0])
      begin
        fine_a_o <= fine[0];
      end
      if (~hr_on)
      begin
        fine_b_o <= 4'h0;
      end
      else if (run & hit[3])
      begin
        fine_b_o <= fine[3];
      end
      else if (run & hit[2])
      begin
        fine_b_o <= fine[2];
      end
    end
  end

  // Sync, sample and blanking outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_o    <= 1'b0;
      error_converter_start_o <= 1'b0;
      blank_a_o <= 1'b0;
      blank_b_o <= 1'b0;
    end
    else
    begin
      sync_o <= run & (cnt_q == phase_q);
      error_converter_start_o <= samp1_hit | samp2_hit;
      if (~run | (run & cnt_q == blk_a_end_q))
      begin
        blank_a_o <= 1'b0;
      end
      else if (cnt_q == blk_a_beg_q)
      begin
        blank_a_o <= 1'b1;
      end
      if (~run | (run & cnt_q == blk_b_end_q))
      begin
        blank_b_o <= 1'b0;
      end
      else if (cnt_q == blk_b_beg_q)
      begin
        blank_b_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test_hrpwm_top.sv
// Self-checking bench for hrpwm_top over Wishbone and its PWM pins.
// Assumes hrpwm_pkg, hrpwm_sib and hrpwm_chk are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_hrpwm_top;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [23:0] duty_i   = 24'h000000;
  logic        sib_run  = 1'b0;
  logic        pol      = 1'b0;
  logic        sync_i, wb_ack_o, pwm_a_o, pwm_b_o, sync_o, error_converter_start_o;
  logic        blank_a_o, blank_b_o, period_irq_o, housekeeping_converter_start_o;
  logic [31:0] wb_dat_o, rdat;
  logic [3:0]  fine_a_o, fine_b_o;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          hi, per, n, e;
  time         t0;
  int          dv[15] = '{0, 1, 3, 7, 15, 31, 47, 63, 79, 95, 127, 159, 191, 223, 255};

  always #20 clk_i = ~clk_i;

  hrpwm_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .duty_i(duty_i), .sync_i(sync_i),
    .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .fine_a_o(fine_a_o), .fine_b_o(fine_b_o),
    .sync_o(sync_o), .error_converter_start_o(error_converter_start_o),
    .blank_a_o(blank_a_o), .blank_b_o(blank_b_o), .period_irq_o(period_irq_o),
    .housekeeping_converter_start_o(housekeeping_converter_start_o)
  );

  hrpwm_sib #(.PER(15)) sib (.clk_i(clk_i), .rst_i(rst_i), .run_i(sib_run), .sync_o(sync_i));

  task stop_test;
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0000_0000);
    check(rdat, x);
  endtask

  function automatic logic sg(input int i);
    case (i)
      0: return pwm_a_o ^ pol;
      1: return pwm_b_o ^ pol;
      2: return blank_a_o;
      default: return blank_b_o;
    endcase
  endfunction

  // Cycles to the next rise of a signal, and its high time on the way
  task rise(input int i, output int h, output int p);
    logic q;
    h = 0;
    p = 0;
    do
    begin
      q = sg(i);
      @(negedge clk_i);
      p++;
      h += (q === 1'b1);
    end
    while (!(sg(i) === 1'b1 && q === 1'b0));
  endtask

  task meas(input int i, input int eh, input int ep);
    rise(i, hi, per);
    rise(i, hi, per);
    check(32'(hi), 32'(eh));
    check(32'(per), 32'(ep));
  endtask

  // Interval between two period interrupts, and sample triggers in it
  task gap;
    n = 0;
    e = 0;
    do
      @(negedge clk_i);
    while (period_irq_o !== 1'b1);
    do
    begin
      @(negedge clk_i);
      n++;
      e += (error_converter_start_o === 1'b1);
    end
    while (period_irq_o !== 1'b1);
  endtask

  initial
  begin
    repeat (90000) @(posedge clk_i);
    n_errors++;
    stop_test;
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(hrpwm_pkg::ADR_CTRL, 32'h0000_0000);
    rc(hrpwm_pkg::ADR_PERIOD, 32'h0000_00FF);
    wr(8'h30, 32'hFFFF_FFFF);
    rc(8'h30, 32'h0000_0000);
    wr(hrpwm_pkg::ADR_A_FALL, 32'hFFFF_FFFF);
    rc(hrpwm_pkg::ADR_A_FALL, 32'h0003_FFFF);
    wr(hrpwm_pkg::ADR_A_RISE, 32'hFFFF_FFFF);
    rc(hrpwm_pkg::ADR_A_RISE, 32'h0000_3FFF);
    wr(hrpwm_pkg::ADR_CTRL, 32'hFFFF_FFFE);
    rc(hrpwm_pkg::ADR_CTRL, 32'h0000_1FFE);
    wr(hrpwm_pkg::ADR_PERIOD, 32'h0000_0009);
    wr(hrpwm_pkg::ADR_A_RISE, 32'h0000_0002);
    wr(hrpwm_pkg::ADR_A_FALL, 32'h0000_0050);
    wr(hrpwm_pkg::ADR_B_RISE, 32'h0000_0030);
    wr(hrpwm_pkg::ADR_B_FALL, 32'h0000_0080);
    wr(hrpwm_pkg::ADR_BLANK_A, 32'h0006_0002);
    wr(hrpwm_pkg::ADR_BLANK_B, 32'h0008_0001);
    wr(hrpwm_pkg::ADR_PHASE, 32'h0000_0004);
    for (int p = 1; p >= 0; p--)
    begin
      wr(hrpwm_pkg::ADR_CTRL, 32'h0000_0001 | (p << 1));
      pol = p[0];
      meas(0, 3, 10);
      meas(1, 5, 10);
    end
    meas(2, 4, 10);
    meas(3, 7, 10);
    n = 0;
    repeat (40)
    begin
      @(negedge clk_i);
      n += (sync_o === 1'b1);
    end
    check(32'(n), 32'h0000_0004);
    wr(hrpwm_pkg::ADR_ADJUST, 32'hFFF0_0020);
    meas(0, 5, 10);
    meas(1, 4, 10);
    wr(hrpwm_pkg::ADR_ADJUST, 32'h0000_0000);
    wr(hrpwm_pkg::ADR_A_FALL, 32'h0000_005B);
    wr(hrpwm_pkg::ADR_B_FALL, 32'h0000_008C);
    for (int s = 0; s < 5; s++)
    begin
      wr(hrpwm_pkg::ADR_CTRL, (s < 4) ? 32'h0000_0085 | (s << 5) : 32'h0000_0005);
      rise(0, hi, per);
      do
        @(negedge clk_i);
      while (pwm_a_o !== 1'b0 || pwm_b_o !== 1'b0);
      check(fine_a_o, (s < 4) ? 4'hB & (4'hF << s) : 4'h0);
      check(fine_b_o, (s < 4) ? 4'hC & (4'hF << s) : 4'h0);
    end
    wr(hrpwm_pkg::ADR_A_FALL, 32'h0000_0050);
    wr(hrpwm_pkg::ADR_CTRL, 32'h0000_1001);
    duty_i <= 24'h400000;
    meas(0, 4, 10);
    duty_i <= 24'h200000;
    meas(0, 2, 10);
    wr(hrpwm_pkg::ADR_CTRL, 32'h0000_0001);
    rise(0, hi, per);
    t0 = $time;
    wr(hrpwm_pkg::ADR_PERIOD, 32'h0000_0013);
    rise(0, hi, per);
    check(32'(($time - t0) / 40), 32'h0000_000A);
    meas(0, 3, 20);
    sib_run <= 1'b1;
    meas(0, 3, 15);
    sib_run <= 1'b0;
    wr(hrpwm_pkg::ADR_PERIOD, 32'h0000_003F);
    wr(hrpwm_pkg::ADR_SAMPLE, 32'h0001_0001);
    for (int os = 0; os < 4; os++)
    begin
      wr(hrpwm_pkg::ADR_CTRL, 32'h0000_0101 | (os << 3));
      gap;
      gap;
      check(32'(n), 32'h0000_0040);
      check(32'(e), 32'(1 << os));
    end
    wr(hrpwm_pkg::ADR_PERIOD, 32'h0000_0009);
    for (int s = 0; s < 15; s++)
    begin
      wr(hrpwm_pkg::ADR_CTRL, 32'h0000_0001 | ((s + 1) << 8));
      gap;
      gap;
      check(32'(n), 32'((dv[s] + 1) * 10));
    end
    stop_test;
  end
endmodule
`default_nettype wire
